// ==== cwl_consts.vh ====
// What this block does
// - copy each flash config word into registers
// - reload on every kind of device reset
// - fetch words from fixed top-of-flash addresses
// - security bit 15 disables alternate vector table
// - config segment level: 111,110,10x,0xx decode
// - security bit 8 low write-protects config segment
// - general segment level: 11,10,0x decode
// - security bit 5 low write-protects general segment
// - security bit 3 high means no boot segment
// - boot segment level: 11,10,0x decode
// - security bit 0 low write-protects boot segment
// - boot limit holds inverted first general page
// - all-ones limit gives zero-size boot segment
// - unimplemented bits read back as one
// - two-speed start runs fast rc first
// - multiplier 1111 none, 1110/1101/1100 8x/6x/4x
// - codes 0000-0111 select 96 mhz multiplier
// - three-bit oscillator source select decode
`ifndef CWL_CONSTS_VH
`define CWL_CONSTS_VH

// ----------------------------------------------------------------------
// word map
// ----------------------------------------------------------------------
`define CWL_WORDS          4'h9
`define CWL_OFS_SEC        24'h02af00
`define CWL_OFS_LIM        24'h02af10
`define CWL_OFS_SIGN       24'h02af14
`define CWL_OFS_OSEL       24'h02af18
`define CWL_OFS_OOPT       24'h02af1c
`define CWL_OFS_WDT        24'h02af20
`define CWL_OFS_POR        24'h02af24
`define CWL_OFS_DBG        24'h02af28
`define CWL_OFS_DEV        24'h02af2c
`define CWL_OFS_STATUS     24'h02af30
`define CWL_OFS_CTRL       24'h02af34
`define CWL_OFS_SUMMARY    24'h02af38

// ----------------------------------------------------------------------
// bits forced to one on capture
// ----------------------------------------------------------------------
`define CWL_UMSK_SEC       24'hff7010
`define CWL_UMSK_LIM       24'hffe000
`define CWL_UMSK_SIGN      24'hff7fff
`define CWL_UMSK_OSEL      24'hfffc00
`define CWL_UMSK_OOPT      24'hffff00
`define CWL_UMSK_WDT       24'hff9400
`define CWL_UMSK_POR       24'hfffff0
`define CWL_UMSK_DBG       24'hffff5c
`define CWL_UMSK_DEV       24'hff0000
`define CWL_WORD_ERASED    24'hffffff

// ----------------------------------------------------------------------
// security and limit fields
// ----------------------------------------------------------------------
`define CWL_SEC_ALTERNATE_VECTOR_TABLE_DIS   15
`define CWL_SEC_CSS_HI     11
`define CWL_SEC_CSS_LO     9
`define CWL_SEC_CWP        8
`define CWL_SEC_GSS_HI     7
`define CWL_SEC_GSS_LO     6
`define CWL_SEC_GWP        5
`define CWL_SEC_BABS       3
`define CWL_SEC_BSS_HI     2
`define CWL_SEC_BSS_LO     1
`define CWL_SEC_BWP        0
`define CWL_LIM_HI         12
`define CWL_LIM_W          13
`define CWL_LVL_NONE       2'h0
`define CWL_LVL_STD        2'h1
`define CWL_LVL_ENH        2'h2
`define CWL_LVL_HIGH       2'h3

// ----------------------------------------------------------------------
// oscillator select fields
// ----------------------------------------------------------------------
`define CWL_OSEL_TWO_SPEED 7
`define CWL_OSEL_MUL_HI    6
`define CWL_OSEL_MUL_LO    3
`define CWL_OSEL_SRC_HI    2
`define CWL_MUL_NONE       4'hf
`define CWL_MUL_X8         4'he
`define CWL_MUL_X6         4'hd
`define CWL_MUL_X4         4'hc
`define CWL_SRC_DIVIDED    3'h7
`define CWL_SRC_RESERVED   3'h6
`define CWL_SRC_FAST_RC    3'h0

// ----------------------------------------------------------------------
// status and control fields
// ----------------------------------------------------------------------
`define CWL_CTRL_RELOAD    0

`endif

// ==== cwl_sec_decode.v ====
`include "cwl_consts.vh"
`default_nettype none

module cwl_sec_decode (
  input  wire [23:0] sec_word_i,
  input  wire [23:0] lim_word_i,
  output reg         alternate_vector_table_disable_o,
  output reg  [1:0]  cfg_level_o,
  output reg         cfg_wp_o,
  output reg  [1:0]  gen_level_o,
  output reg         gen_wp_o,
  output reg         boot_absent_o,
  output reg  [1:0]  boot_level_o,
  output reg         boot_wp_o,
  output reg  [12:0] boot_first_gen_page_o
);

  // 0x in a two-bit field means high security
  function [1:0] cwl_lvl2;
    input [1:0] f;
    begin
      if (f == 2'h3)
        cwl_lvl2 = `CWL_LVL_NONE;
      else if (f == 2'h2)
        cwl_lvl2 = `CWL_LVL_STD;
      else
        cwl_lvl2 = `CWL_LVL_HIGH;
    end
  endfunction

  always @* begin
    alternate_vector_table_disable_o = sec_word_i[`CWL_SEC_ALTERNATE_VECTOR_TABLE_DIS];
    case (sec_word_i[`CWL_SEC_CSS_HI:`CWL_SEC_CSS_LO])
      3'h7:    cfg_level_o = `CWL_LVL_NONE;
      3'h6:    cfg_level_o = `CWL_LVL_STD;
      3'h5,
      3'h4:    cfg_level_o = `CWL_LVL_ENH;
      default: cfg_level_o = `CWL_LVL_HIGH;
    endcase
    cfg_wp_o      = ~sec_word_i[`CWL_SEC_CWP];
    gen_level_o   = cwl_lvl2(sec_word_i[`CWL_SEC_GSS_HI:`CWL_SEC_GSS_LO]);
    gen_wp_o      = ~sec_word_i[`CWL_SEC_GWP];
    boot_absent_o = sec_word_i[`CWL_SEC_BABS];
    boot_level_o  = cwl_lvl2(sec_word_i[`CWL_SEC_BSS_HI:`CWL_SEC_BSS_LO]);
    boot_wp_o     = ~sec_word_i[`CWL_SEC_BWP];
    // erased limit inverts to page 0, i.e. empty boot segment
    if (boot_absent_o)
      boot_first_gen_page_o = {`CWL_LIM_W{1'b0}};
    else
      boot_first_gen_page_o = ~lim_word_i[`CWL_LIM_HI:0];
  end

endmodule

`default_nettype wire

// ==== cwl_osc_decode.v ====
`include "cwl_consts.vh"
`default_nettype none

module cwl_osc_decode (
  input  wire [23:0] osel_word_i,
  output reg         two_speed_o,
  output reg  [2:0]  target_src_o,
  output reg  [2:0]  start_src_o,
  output reg         src_reserved_o,
  output reg         mul_enable_avail_o,
  output reg  [3:0]  mul_factor_o,
  output reg         pll96_sel_o,
  output reg  [5:0]  pll96_in_mhz_o
);

  reg [3:0] mode;

  always @* begin
    mode = osel_word_i[`CWL_OSEL_MUL_HI:`CWL_OSEL_MUL_LO];
    two_speed_o    = osel_word_i[`CWL_OSEL_TWO_SPEED];
    target_src_o   = osel_word_i[`CWL_OSEL_SRC_HI:0];
    src_reserved_o = (target_src_o == `CWL_SRC_RESERVED);
    // two-speed start runs on fast rc until the target is ready
    start_src_o = two_speed_o ? `CWL_SRC_FAST_RC : target_src_o;
    mul_enable_avail_o = (mode != `CWL_MUL_NONE);
    pll96_sel_o        = ~mode[3];
    case (mode)
      `CWL_MUL_X8: mul_factor_o = 4'h8;
      `CWL_MUL_X6: mul_factor_o = 4'h6;
      `CWL_MUL_X4: mul_factor_o = 4'h4;
      default:     mul_factor_o = 4'h0;
    endcase
    case (mode)
      4'h0:    pll96_in_mhz_o = 6'h04;
      4'h1:    pll96_in_mhz_o = 6'h08;
      4'h2:    pll96_in_mhz_o = 6'h0c;
      4'h3:    pll96_in_mhz_o = 6'h10;
      4'h4:    pll96_in_mhz_o = 6'h14;
      4'h5:    pll96_in_mhz_o = 6'h18;
      4'h6:    pll96_in_mhz_o = 6'h20;
      4'h7:    pll96_in_mhz_o = 6'h30;
      default: pll96_in_mhz_o = 6'h00;
    endcase
  end

endmodule

`default_nettype wire

// ==== cwl_loader.v ====
// The plain strobed port was chosen for this implementation.
`include "cwl_consts.vh"
`default_nettype none

module cwl_loader (
  input  wire        clock_i,
  input  wire        rst_i,
  // any other device reset source, one-cycle pulse
  input  wire        dev_reset_req_i,
  // program flash read port
  output reg         flash_rd_o,
  output reg  [23:0] flash_addr_o,
  input  wire [23:0] flash_rdata_i,
  input  wire        flash_valid_i,
  // reset held over the rest of the device
  output reg         sys_rst_o,
  output reg         cfg_valid_o,
  // register port
  input  wire [23:0] reg_addr_i,
  input  wire [31:0] reg_wdata_i,
  input  wire        reg_wr_i,
  input  wire        reg_rd_i,
  output reg  [31:0] reg_rdata_o,
  // decoded security
  output reg         alt_vector_table_disable_o,
  output reg         alt_vector_table_runtime_enable_avail_o,
  output reg  [1:0]  config_segment_protect_level_o,
  output reg         config_segment_write_protect_o,
  output reg  [1:0]  general_segment_protect_level_o,
  output reg         general_segment_write_protect_o,
  output reg         boot_segment_absent_o,
  output reg  [1:0]  boot_segment_protect_level_o,
  output reg         boot_segment_write_protect_o,
  output reg  [12:0] boot_first_general_page_o,
  // decoded oscillator select
  output reg         two_speed_startup_enable_o,
  output reg  [2:0]  initial_oscillator_select_o,
  output reg  [2:0]  startup_oscillator_o,
  output reg         oscillator_select_reserved_o,
  output reg         multiplier_runtime_enable_avail_o,
  output reg  [3:0]  multiplier_factor_o,
  output reg         pll96_select_o,
  output reg  [5:0]  pll96_input_mhz_o
);

  // ------------
  // states
  // ------------
  localparam [1:0] ST_ISSUE  = 2'h0;
  localparam [1:0] ST_WAIT   = 2'h1;
  localparam [1:0] ST_FINISH = 2'h2;
  localparam [1:0] ST_DONE   = 2'h3;

  // ------------
  // lookup functions
  // ------------
  function [23:0] cwl_word_addr;
    input [3:0] idx;
    begin
      case (idx)
        4'h0:    cwl_word_addr = `CWL_OFS_SEC;
        4'h1:    cwl_word_addr = `CWL_OFS_LIM;
        4'h2:    cwl_word_addr = `CWL_OFS_SIGN;
        4'h3:    cwl_word_addr = `CWL_OFS_OSEL;
        4'h4:    cwl_word_addr = `CWL_OFS_OOPT;
        4'h5:    cwl_word_addr = `CWL_OFS_WDT;
        4'h6:    cwl_word_addr = `CWL_OFS_POR;
        4'h7:    cwl_word_addr = `CWL_OFS_DBG;
        default: cwl_word_addr = `CWL_OFS_DEV;
      endcase
    end
  endfunction

  function [23:0] cwl_unimpl_mask;
    input [3:0] idx;
    begin
      case (idx)
        4'h0:    cwl_unimpl_mask = `CWL_UMSK_SEC;
        4'h1:    cwl_unimpl_mask = `CWL_UMSK_LIM;
        4'h2:    cwl_unimpl_mask = `CWL_UMSK_SIGN;
        4'h3:    cwl_unimpl_mask = `CWL_UMSK_OSEL;
        4'h4:    cwl_unimpl_mask = `CWL_UMSK_OOPT;
        4'h5:    cwl_unimpl_mask = `CWL_UMSK_WDT;
        4'h6:    cwl_unimpl_mask = `CWL_UMSK_POR;
        4'h7:    cwl_unimpl_mask = `CWL_UMSK_DBG;
        default: cwl_unimpl_mask = `CWL_UMSK_DEV;
      endcase
    end
  endfunction

  // ------------
  // state
  // ------------
  reg [1:0]  state_q;
  reg [3:0]  idx_q;
  reg [7:0]  load_cnt_q;
  reg        reload_q;
  reg        pend_q;
  reg [23:0] words_q [0:8];

  // an internal reset source or a reload write restarts the load
  wire restart = dev_reset_req_i | reload_q;

  // ------------
  // register port decode
  // ------------
  // word offsets never overlap, so at most one index matches
  reg        hit_word;
  reg [3:0]  hit_idx;
  integer    k;

  always @* begin
    hit_word = 1'b0;
    hit_idx  = 4'h0;
    for (k = 0; k < 9; k = k + 1) begin
      if (reg_addr_i == cwl_word_addr(k[3:0])) begin
        hit_word = 1'b1;
        hit_idx  = k[3:0];
      end
    end
  end

  // ------------
  // decoders
  // ------------
  wire        d_alternate_vector_table_dis;
  wire [1:0]  d_cfg_lvl;
  wire        d_cfg_wp;
  wire [1:0]  d_gen_lvl;
  wire        d_gen_wp;
  wire        d_boot_abs;
  wire [1:0]  d_boot_lvl;
  wire        d_boot_wp;
  wire [12:0] d_boot_page;
  wire        d_two_speed;
  wire [2:0]  d_target;
  wire [2:0]  d_start;
  wire        d_src_rsvd;
  wire        d_mul_avail;
  wire [3:0]  d_mul_fac;
  wire        d_pll96;
  wire [5:0]  d_pll96_mhz;

  cwl_sec_decode u_sec (
    .sec_word_i            (words_q[0]),
    .lim_word_i            (words_q[1]),
    .alternate_vector_table_disable_o        (d_alternate_vector_table_dis),
    .cfg_level_o           (d_cfg_lvl),
    .cfg_wp_o              (d_cfg_wp),
    .gen_level_o           (d_gen_lvl),
    .gen_wp_o              (d_gen_wp),
    .boot_absent_o         (d_boot_abs),
    .boot_level_o          (d_boot_lvl),
    .boot_wp_o             (d_boot_wp),
    .boot_first_gen_page_o (d_boot_page)
  );

  cwl_osc_decode u_osc (
    .osel_word_i        (words_q[3]),
    .two_speed_o        (d_two_speed),
    .target_src_o       (d_target),
    .start_src_o        (d_start),
    .src_reserved_o     (d_src_rsvd),
    .mul_enable_avail_o (d_mul_avail),
    .mul_factor_o       (d_mul_fac),
    .pll96_sel_o        (d_pll96),
    .pll96_in_mhz_o     (d_pll96_mhz)
  );

  // ------------
  // load sequencer
  // ------------
  // a read cut off by a restart still gets its answer from the flash;
  // no new read goes out until that late answer has gone by
  always @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      pend_q <= 1'b0;
    end else begin
      pend_q <= flash_rd_o | (pend_q & ~flash_valid_i);
    end
  end

  always @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      state_q      <= ST_ISSUE;
      idx_q        <= 4'h0;
      flash_rd_o   <= 1'b0;
      flash_addr_o <= `CWL_OFS_SEC;
      sys_rst_o    <= 1'b1;
      cfg_valid_o  <= 1'b0;
      load_cnt_q   <= 8'h00;
    end else if (restart) begin
      // any reset source starts a fresh load from the first word
      state_q     <= ST_ISSUE;
      idx_q       <= 4'h0;
      flash_rd_o  <= 1'b0;
      sys_rst_o   <= 1'b1;
      cfg_valid_o <= 1'b0;
    end else begin
      // read strobe is a one-cycle pulse
      flash_rd_o <= 1'b0;
      case (state_q)
        ST_ISSUE: begin
          if (!pend_q) begin
            flash_rd_o   <= 1'b1;
            flash_addr_o <= cwl_word_addr(idx_q);
            state_q      <= ST_WAIT;
          end
        end
        ST_WAIT: begin
          if (flash_valid_i) begin
            if (idx_q == `CWL_WORDS - 4'h1) begin
              state_q <= ST_FINISH;
            end else begin
              idx_q   <= idx_q + 4'h1;
              state_q <= ST_ISSUE;
            end
          end
        end
        ST_FINISH: begin
          // decoders settle on the full word set before release
          sys_rst_o   <= 1'b0;
          cfg_valid_o <= 1'b1;
          load_cnt_q  <= load_cnt_q + 8'h01;
          state_q     <= ST_DONE;
        end
        ST_DONE: begin
          state_q <= ST_DONE;
        end
        default: begin
          state_q <= ST_ISSUE;
        end
      endcase
    end
  end

  // ------------
  // word capture
  // ------------
  genvar g;
  generate
    for (g = 0; g < 9; g = g + 1) begin : g_word
      always @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
          words_q[g] <= `CWL_WORD_ERASED;
        end else if (state_q == ST_WAIT && flash_valid_i && !restart &&
                     idx_q == g) begin
          // upper byte and unimplemented bits forced to one
          words_q[g] <= flash_rdata_i | cwl_unimpl_mask(g);
        end
      end
    end
  endgenerate

  // ------------
  // decoded outputs, latched once per load
  // ------------
  always @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      alt_vector_table_disable_o              <= 1'b1;
      alt_vector_table_runtime_enable_avail_o <= 1'b0;
      config_segment_protect_level_o          <= `CWL_LVL_NONE;
      config_segment_write_protect_o          <= 1'b0;
      general_segment_protect_level_o         <= `CWL_LVL_NONE;
      general_segment_write_protect_o         <= 1'b0;
      boot_segment_absent_o                   <= 1'b1;
      boot_segment_protect_level_o            <= `CWL_LVL_NONE;
      boot_segment_write_protect_o            <= 1'b0;
      boot_first_general_page_o               <= 13'h0000;
      two_speed_startup_enable_o              <= 1'b1;
      initial_oscillator_select_o             <= `CWL_SRC_DIVIDED;
      startup_oscillator_o                    <= `CWL_SRC_FAST_RC;
      oscillator_select_reserved_o            <= 1'b0;
      multiplier_runtime_enable_avail_o       <= 1'b0;
      multiplier_factor_o                     <= 4'h0;
      pll96_select_o                          <= 1'b0;
      pll96_input_mhz_o                       <= 6'h00;
    end else if (state_q == ST_FINISH && !restart) begin
      alt_vector_table_disable_o              <= d_alternate_vector_table_dis;
      alt_vector_table_runtime_enable_avail_o <= ~d_alternate_vector_table_dis;
      config_segment_protect_level_o          <= d_cfg_lvl;
      config_segment_write_protect_o          <= d_cfg_wp;
      general_segment_protect_level_o         <= d_gen_lvl;
      general_segment_write_protect_o         <= d_gen_wp;
      boot_segment_absent_o                   <= d_boot_abs;
      boot_segment_protect_level_o            <= d_boot_lvl;
      boot_segment_write_protect_o            <= d_boot_wp;
      boot_first_general_page_o               <= d_boot_page;
      two_speed_startup_enable_o              <= d_two_speed;
      initial_oscillator_select_o             <= d_target;
      startup_oscillator_o                    <= d_start;
      oscillator_select_reserved_o            <= d_src_rsvd;
      multiplier_runtime_enable_avail_o       <= d_mul_avail;
      multiplier_factor_o                     <= d_mul_fac;
      pll96_select_o                          <= d_pll96;
      pll96_input_mhz_o                       <= d_pll96_mhz;
    end
  end

  // ------------
  // register port
  // ------------
  // config words are read only; a write there is dropped
  always @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      reload_q    <= 1'b0;
      reg_rdata_o <= 32'h00000000;
    end else begin
      reload_q <= reg_wr_i &&
                  reg_addr_i == `CWL_OFS_CTRL &&
                  reg_wdata_i[`CWL_CTRL_RELOAD];
      reg_rdata_o <= 32'h00000000;
      if (reg_rd_i) begin
        if (hit_word) begin
          reg_rdata_o <= {8'h00, words_q[hit_idx]};
        end else if (reg_addr_i == `CWL_OFS_STATUS) begin
          reg_rdata_o <= {16'h0000,
                          load_cnt_q,
                          2'h0,
                          idx_q,
                          sys_rst_o,
                          cfg_valid_o};
        end else if (reg_addr_i == `CWL_OFS_SUMMARY) begin
          reg_rdata_o <= {5'h00,
                          boot_first_general_page_o,
                          pll96_select_o,
                          multiplier_factor_o,
                          initial_oscillator_select_o,
                          boot_segment_absent_o,
                          boot_segment_write_protect_o,
                          general_segment_write_protect_o,
                          config_segment_write_protect_o,
                          alt_vector_table_disable_o,
                          two_speed_startup_enable_o};
        end
      end
    end
  end

endmodule

`default_nettype wire

// ==== cwl_loader_chk.sv ====
`default_nettype none
module cwl_chk (
  input wire logic        clock_i,
  input wire logic        rst_i,
  input wire logic        flash_rd_o,
  input wire logic [23:0] flash_addr_o,
  input wire logic        sys_rst_o,
  input wire logic        cfg_valid_o,
  input wire logic        reg_rd_i,
  input wire logic [23:0] reg_addr_i,
  input wire logic [31:0] reg_rdata_o,
  input wire logic        alt_vector_table_disable_o,
  input wire logic        alt_vector_table_runtime_enable_avail_o,
  input wire logic        boot_segment_absent_o,
  input wire logic [12:0] boot_first_general_page_o,
  input wire logic        two_speed_startup_enable_o,
  input wire logic [2:0]  initial_oscillator_select_o,
  input wire logic [2:0]  startup_oscillator_o,
  input wire logic        multiplier_runtime_enable_avail_o,
  input wire logic [3:0]  multiplier_factor_o,
  input wire logic        pll96_select_o
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking @(posedge clock_i); endclocking
  default disable iff (rst_i);
  // ------------
  // load sequencing
  // ------------
  sequence load_go;
    flash_rd_o && flash_addr_o == 24'h02af00;
  endsequence
  rd_pulse_a: assert property (flash_rd_o |=> !flash_rd_o)
    else $error("flash strobe too long");
  load_start_a: assert property ($fell(rst_i) |-> ##[0:1] load_go)
    else $error("load did not start");
  reload_go_a: assert property ($rose(sys_rst_o) |-> ##[0:3] load_go)
    else $error("reload did not start");
  hold_rst_a: assert property (sys_rst_o |-> !cfg_valid_o)
    else $error("valid during reset");
  freeze_out_a: assert property (sys_rst_o && $past(sys_rst_o) |->
    $stable(boot_first_general_page_o) && $stable(multiplier_factor_o))
    else $error("outputs moved in load");
  // ------------
  // register port and decode relations
  // ------------
  sign_read_a: assert property (reg_rd_i && reg_addr_i == 24'h02af14
    |=> reg_rdata_o[31:16] == 16'h00ff && reg_rdata_o[14:0] == 15'h7fff)
    else $error("unimplemented bits not one");
  idle_read_a: assert property (!reg_rd_i |=> reg_rdata_o == 32'h0)
    else $error("read data outside its cycle");
  vec_pair_a: assert property (alt_vector_table_disable_o !=
    alt_vector_table_runtime_enable_avail_o)
    else $error("vector table availability wrong");
  boot_empty_a: assert property (boot_segment_absent_o |->
    boot_first_general_page_o == 13'h0)
    else $error("absent boot segment sized");
  start_osc_a: assert property (startup_oscillator_o ==
    (two_speed_startup_enable_o ? 3'h0 : initial_oscillator_select_o))
    else $error("start-up oscillator wrong");
  mul_avail_a: assert property (multiplier_factor_o != 4'h0 |->
    multiplier_runtime_enable_avail_o && !pll96_select_o)
    else $error("multiplier companions wrong");
endmodule
bind cwl_loader cwl_chk cwl_chk_i (.*);
`default_nettype wire

// ==== cwl_flash_model.sv ====
`default_nettype none
module cwl_flash (
  input  wire logic        clock_i,
  input  wire logic        rst_i,
  input  wire logic        rd_i,
  input  wire logic [23:0] addr_i,
  input  wire logic [1:0]  lat_i,
  output var  logic [23:0] rdata_o,
  output var  logic        valid_o
);
  timeunit 1ns;
  timeprecision 100ps;
  // config locations hold config data only, never code
  logic [23:0] mem [0:8];
  logic [23:0] a_q;
  logic [1:0]  cnt_q;
  function automatic int idx(input logic [23:0] a);
    return (a[7:0] == 8'h00) ? 0 : int'((a[7:0] - 8'h0c) >> 2);
  endfunction
  // idle data toggles so a stale word never passes as fresh
  always @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      cnt_q <= 2'h0;
      valid_o <= 1'b0;
      rdata_o <= 24'h0;
    end else begin
      valid_o <= 1'b0;
      rdata_o <= ~rdata_o;
      if (rd_i) begin
        cnt_q <= lat_i;
        a_q <= addr_i;
      end else if (cnt_q == 2'h1) begin
        cnt_q <= 2'h0;
        valid_o <= 1'b1;
        rdata_o <= {8'h00, mem[idx(a_q)][15:0]};
      end else if (cnt_q != 2'h0) begin
        cnt_q <= cnt_q - 2'h1;
      end
    end
  end
endmodule
`default_nettype wire

// ==== cwl_loader_tb_top.sv ====
`include "cwl_consts.vh"
`default_nettype none
module cwl_loader_tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  logic clock_i, rst_i, dev_reset_req_i, flash_rd_o, flash_valid_i;
  logic sys_rst_o, cfg_valid_o, reg_wr_i, reg_rd_i, pll96_select_o;
  logic alt_vector_table_disable_o, alt_vector_table_runtime_enable_avail_o;
  logic config_segment_write_protect_o, general_segment_write_protect_o;
  logic boot_segment_absent_o, boot_segment_write_protect_o;
  logic two_speed_startup_enable_o, oscillator_select_reserved_o;
  logic multiplier_runtime_enable_avail_o;
  logic [1:0]  config_segment_protect_level_o, lat;
  logic [1:0]  general_segment_protect_level_o, boot_segment_protect_level_o;
  logic [2:0]  initial_oscillator_select_o, startup_oscillator_o;
  logic [3:0]  multiplier_factor_o;
  logic [5:0]  pll96_input_mhz_o;
  logic [12:0] boot_first_general_page_o;
  logic [23:0] flash_addr_o, flash_rdata_i, reg_addr_i, s, l, o, ws [9];
  logic [31:0] reg_wdata_i, reg_rdata_o, rdat;
  logic [23:0] aq [$];
  logic [23:0] ad [9] = '{`CWL_OFS_SEC, `CWL_OFS_LIM, `CWL_OFS_SIGN,
    `CWL_OFS_OSEL, `CWL_OFS_OOPT, `CWL_OFS_WDT, `CWL_OFS_POR,
    `CWL_OFS_DBG, `CWL_OFS_DEV};
  logic [23:0] ms [9] = '{`CWL_UMSK_SEC, `CWL_UMSK_LIM, `CWL_UMSK_SIGN,
    `CWL_UMSK_OSEL, `CWL_UMSK_OOPT, `CWL_UMSK_WDT, `CWL_UMSK_POR,
    `CWL_UMSK_DBG, `CWL_UMSK_DEV};
  int mt [8] = '{4, 8, 12, 16, 20, 24, 32, 48};
  int fails, cmp_count, cyc, n;
  cwl_loader cwl_loader_i (.*);
  cwl_flash cwl_flash_i (.clock_i, .rst_i, .rd_i(flash_rd_o),
    .addr_i(flash_addr_o), .lat_i(lat), .rdata_o(flash_rdata_i),
    .valid_o(flash_valid_i));
  // ------------
  // compare and bus tasks
  // ------------
  task automatic chk_reg(input logic [31:0] g, e);
    cmp_count++;
    if (g !== e) begin
      fails++;
      $display("Error %0t: reg got %h exp %h", $time, g, e);
    end
  endtask
  task automatic chk_fld(input logic [31:0] g, e);
    cmp_count++;
    if (g !== e) begin
      fails++;
      $display("Error %0t: field got %h exp %h", $time, g, e);
    end
  endtask
  task automatic rd_reg(input logic [23:0] a, output logic [31:0] d);
    reg_addr_i <= a;
    reg_rd_i <= 1'b1;
    @(posedge clock_i);
    reg_rd_i <= 1'b0;
    @(posedge clock_i);
    d = reg_rdata_o;
  endtask
  task automatic wr_reg(input logic [23:0] a, input logic [31:0] d);
    reg_addr_i <= a;
    reg_wdata_i <= d;
    reg_wr_i <= 1'b1;
    @(posedge clock_i);
    reg_wr_i <= 1'b0;
  endtask
  function automatic logic [1:0] lvl2(input logic [1:0] f);
    return f == 2'h3 ? 2'h0 : f == 2'h2 ? 2'h1 : 2'h3;
  endfunction
  task automatic close_out;
    $display("fails=%0d cmp_count=%0d", fails, cmp_count);
    if (fails == 0 && cmp_count > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  // ------------
  // clock, address capture, timeout
  // ------------
  initial begin
    clock_i = 1'b0;
    forever #2.5 clock_i = ~clock_i;
  end
  always @(posedge clock_i) begin
    cyc++;
    if (flash_rd_o === 1'b1) aq.push_back(flash_addr_o);
    if (cyc == 6000) begin
      fails++;
      close_out;
    end
  end
  // ------------
  // main sequence
  // ------------
  initial begin
    rst_i = 1'b1;
    dev_reset_req_i = 1'b0;
    reg_rd_i = 1'b0;
    reg_wr_i = 1'b0;
    reg_addr_i = 24'h0;
    reg_wdata_i = 32'h0;
    lat = 2'h1;
    void'($urandom(32'h17b09491));
    repeat (4) @(posedge clock_i);
    for (int i = 0; i < 16; i++) begin
      for (int k = 0; k < 9; k++) ws[k] = $urandom & 24'h00ffff;
      ws[0][11:9] = i[2:0];
      ws[0][7:6] = i[1:0];
      ws[0][2:1] = i[3:2];
      ws[0][3] = i[0];
      if (i == 4) ws[1][12:0] = 13'h1fff;
      ws[2][15] = 1'b0;
      ws[3][9:8] = 2'h0;
      ws[3][6:0] = {i[3:0], i[2:0]};
      for (int k = 0; k < 9; k++) cwl_flash_i.mem[k] = ws[k];
      aq.delete();
      lat <= 2'($urandom_range(3, 1));
      case (i % 3)
        0: begin
          rst_i <= 1'b1;
          @(posedge clock_i);
          rst_i <= 1'b0;
        end
        1: begin
          dev_reset_req_i <= 1'b1;
          @(posedge clock_i);
          dev_reset_req_i <= 1'b0;
        end
        default: wr_reg(`CWL_OFS_CTRL, 32'h1);
      endcase
      repeat (4) @(posedge clock_i);
      // restart in mid-load must abandon the partial load
      if (i % 4 == 3) begin
        dev_reset_req_i <= 1'b1;
        @(posedge clock_i);
        dev_reset_req_i <= 1'b0;
        repeat (3) @(posedge clock_i);
      end
      n = 0;
      while (cfg_valid_o !== 1'b1 && n < 200) begin
        @(posedge clock_i);
        n++;
      end
      chk_fld(n < 200, 1);
      for (int k = 0; k < 9; k++) begin
        chk_reg(aq[aq.size() - 9 + k], ad[k]);
        rd_reg(ad[k], rdat);
        chk_reg(rdat, {8'h0, ws[k] | ms[k]});
      end
      s = ws[0];
      l = ws[1];
      o = ws[3];
      chk_fld(alt_vector_table_disable_o, s[15]);
      chk_fld(config_segment_protect_level_o, s[11:9] == 3'h7 ? 0 :
        s[11:9] == 3'h6 ? 1 : s[11] ? 2 : 3);
      chk_fld(config_segment_write_protect_o, !s[8]);
      chk_fld(general_segment_protect_level_o, lvl2(s[7:6]));
      chk_fld(general_segment_write_protect_o, !s[5]);
      chk_fld(boot_segment_absent_o, s[3]);
      chk_fld(boot_segment_protect_level_o, lvl2(s[2:1]));
      chk_fld(boot_segment_write_protect_o, !s[0]);
      chk_fld(boot_first_general_page_o,
        s[3] ? 0 : l[12:0] ^ 13'h1fff);
      chk_fld(two_speed_startup_enable_o, o[7]);
      chk_fld(startup_oscillator_o, o[7] ? 0 : o[2:0]);
      chk_fld(initial_oscillator_select_o, o[2:0]);
      chk_fld(oscillator_select_reserved_o, o[2:0] == 3'h6);
      chk_fld(multiplier_runtime_enable_avail_o, o[6:3] != 4'hf);
      chk_fld(multiplier_factor_o, o[6:3] == 4'he ? 8 :
        o[6:3] == 4'hd ? 6 : o[6:3] == 4'hc ? 4 : 0);
      chk_fld(pll96_select_o, !o[6]);
      chk_fld(pll96_input_mhz_o, o[6] ? 0 : mt[o[5:3]]);
      rd_reg(`CWL_OFS_STATUS, rdat);
      chk_reg(rdat, {16'h0, 8'(i % 3 + 1), 8'h21});
    end
    wr_reg(`CWL_OFS_SEC, 32'h0);
    rd_reg(`CWL_OFS_SEC, rdat);
    chk_reg(rdat, {8'h0, ws[0] | ms[0]});
    rd_reg(24'h02af3c, rdat);
    chk_reg(rdat, 32'h0);
    close_out;
  end
endmodule
`default_nettype wire
